// ### rtl/epg_energy_pulse.sv
// Digital-to-frequency output stage driving energy and calibration pulses
module epg_energy_pulse
    import epg_pkg::*;
#(
    parameter int unsigned PWR_W             = 24,
    parameter int unsigned ACC_W             = 48,
    parameter int unsigned ENERGY_LOG2       = 36,
    parameter int unsigned NOLOAD_LEVEL      = ((1 << 24) - 1) * NOLOAD_PPM / MILLION,
    parameter int unsigned CAL_WIDTH         = CAL_WIDTH_CYC,
    parameter int unsigned CAL_HALF_LIMIT    = CAL_HALF_LIMIT_CYC,
    parameter int unsigned ENERGY_WIDTH      = ENERGY_WIDTH_CYC,
    parameter int unsigned ENERGY_HALF_LIMIT = ENERGY_HALF_LIMIT_CYC
) (
    // Clock and reset
    input  wire logic             clock,
    input  wire logic             resetn,
    // Filtered real power
    input  wire logic [PWR_W-1:0] power_sample,
    input  wire logic             power_valid,
    // Static rate selects
    input  wire logic             freq_select_lo,
    input  wire logic             freq_select_hi,
    input  wire logic             cal_scale_select,
    // Pulse outputs
    output logic                  energy_pulse_a,
    output logic                  energy_pulse_b,
    output logic                  calibration_pulse_out
);

    if (ENERGY_LOG2 < 11 || ENERGY_LOG2 + 4 > ACC_W || PWR_W >= ACC_W) begin : g_bad_cfg
        $error("accumulator too narrow for selected thresholds");
    end

    localparam logic [ACC_W-1:0] ACC_ONE  = {{(ACC_W-1){1'b0}}, 1'b1};
    localparam logic [PWR_W-1:0] NOLOAD_W = PWR_W'(NOLOAD_LEVEL);

    // ------------------------------------------------------------
    // Threshold selection
    // ------------------------------------------------------------
    logic [1:0]       sel;
    logic             hf_mode;
    logic [3:0]       cal_shift;
    logic [ACC_W-1:0] energy_thresh;
    logic [ACC_W-1:0] cal_thresh;

    // Power-of-two thresholds keep each base rate a binary fraction of the clock
    always_comb begin
        sel           = {freq_select_hi, freq_select_lo};
        hf_mode       = !cal_scale_select && sel == SEL_HF;
        energy_thresh = ACC_ONE << (ENERGY_LOG2 + {30'h0, ~sel});
        if (hf_mode) begin
            cal_shift = SHIFT_HF;
        end else if (cal_scale_select) begin
            cal_shift = SHIFT_SCF_HI - {2'h0, sel};
        end else begin
            cal_shift = SHIFT_SCF_LO - {2'h0, sel};
        end
        cal_thresh = energy_thresh >> cal_shift;
    end

    // ------------------------------------------------------------
    // Accumulators
    // ------------------------------------------------------------
    logic [ACC_W-1:0] energy_acc;
    logic [ACC_W-1:0] cal_acc;
    logic [ACC_W-1:0] next_energy_acc;
    logic [ACC_W-1:0] next_cal_acc;
    logic             energy_fire;
    logic             cal_fire;
    logic             next_energy_fire;
    logic             next_cal_fire;
    logic             take;
    logic [ACC_W-1:0] e_sum;
    logic [ACC_W-1:0] c_sum;

    // Creep guard drops tiny samples instead of letting them trickle in
    always_comb begin
        take             = power_valid && power_sample >= NOLOAD_W;
        e_sum            = energy_acc + ACC_W'(power_sample);
        c_sum            = cal_acc + ACC_W'(power_sample);
        next_energy_acc  = energy_acc;
        next_cal_acc     = cal_acc;
        next_energy_fire = 1'b0;
        next_cal_fire    = 1'b0;
        if (take) begin
            next_energy_acc = e_sum;
            next_cal_acc    = c_sum;
            if (e_sum >= energy_thresh) begin
                next_energy_acc  = e_sum - energy_thresh;
                next_energy_fire = 1'b1;
            end
            // Short interval: ripple on the power passes to the rate
            if (c_sum >= cal_thresh) begin
                next_cal_acc  = c_sum - cal_thresh;
                next_cal_fire = 1'b1;
            end
        end
    end

    always_ff @(posedge clock or negedge resetn) begin
        if (!resetn) begin
            energy_acc  <= {ACC_W{1'b0}};
            cal_acc     <= {ACC_W{1'b0}};
            energy_fire <= 1'b0;
            cal_fire    <= 1'b0;
        end else begin
            energy_acc  <= next_energy_acc;
            cal_acc     <= next_cal_acc;
            energy_fire <= next_energy_fire;
            cal_fire    <= next_cal_fire;
        end
    end

    // ------------------------------------------------------------
    // Pulse timers
    // ------------------------------------------------------------
    logic energy_active;
    logic cal_active;

    epg_pulse_timer #(
        .NOMINAL_CYC    (ENERGY_WIDTH),
        .HALF_LIMIT_CYC (ENERGY_HALF_LIMIT),
        .FIXED_CYC      (ENERGY_WIDTH)
    ) u_energy_timer (
        .clock      (clock),
        .resetn     (resetn),
        .fire       (energy_fire),
        .fixed_mode (1'b0),
        .active     (energy_active)
    );

    epg_pulse_timer #(
        .NOMINAL_CYC    (CAL_WIDTH),
        .HALF_LIMIT_CYC (CAL_HALF_LIMIT),
        .FIXED_CYC      (HF_WIDTH_CYC)
    ) u_cal_timer (
        .clock      (clock),
        .resetn     (resetn),
        .fire       (cal_fire),
        .fixed_mode (hf_mode),
        .active     (cal_active)
    );

    // ------------------------------------------------------------
    // Output stage
    // ------------------------------------------------------------
    logic phase_b;
    logic next_phase_b;
    logic next_pulse_a;
    logic next_pulse_b;
    logic next_cal_out;

    // Phase flips at each energy pulse so the two pins take turns
    always_comb begin
        next_phase_b = energy_fire ? ~phase_b : phase_b;
        next_pulse_a = ~(energy_active && !phase_b);
        next_pulse_b = ~(energy_active && phase_b);
        next_cal_out = cal_active;
    end

    always_ff @(posedge clock or negedge resetn) begin
        if (!resetn) begin
            phase_b               <= 1'b1;
            energy_pulse_a        <= 1'b1;
            energy_pulse_b        <= 1'b1;
            calibration_pulse_out <= 1'b0;
        end else begin
            phase_b               <= next_phase_b;
            energy_pulse_a        <= next_pulse_a;
            energy_pulse_b        <= next_pulse_b;
            calibration_pulse_out <= next_cal_out;
        end
    end

    // ------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------
    default clocking cb @(posedge clock); endclocking
    default disable iff (!resetn);

    logic last_low_a;

    always_ff @(posedge clock or negedge resetn) begin
        if (!resetn) begin
            last_low_a <= 1'b0;
        end else if ($fell(energy_pulse_a)) begin
            last_low_a <= 1'b1;
        end else if ($fell(energy_pulse_b)) begin
            last_low_a <= 1'b0;
        end
    end

    sequence s_energy_fire;
        energy_fire;
    endsequence

    sequence s_cal_fire_out;
        cal_fire ##2 calibration_pulse_out;
    endsequence

    never_both_low_a: assert property (energy_pulse_a || energy_pulse_b)
        else $error("both energy outputs low");
    alt_order_a: assert property ($fell(energy_pulse_a) |-> !last_low_a)
        else $error("energy output a pulsed twice in a row");
    energy_to_pin_a: assert property (s_energy_fire |-> ##2 (!energy_pulse_a || !energy_pulse_b))
        else $error("energy pulse not driven low");
    cal_to_pin_a: assert property (cal_fire |-> s_cal_fire_out)
        else $error("calibration pulse not raised");
    noload_hold_a: assert property (!take |=> $stable(energy_acc) && $stable(cal_acc) && !energy_fire)
        else $error("sub-threshold load accumulated");
    hf_shift_a: assert property (hf_mode |-> cal_shift == SHIFT_HF && (cal_thresh << 11) == energy_thresh)
        else $error("high frequency multiple wrong");
    cal_ratio_a: assert property (!hf_mode |-> (cal_thresh << cal_shift) == energy_thresh
                                  && cal_shift == (cal_scale_select ? 4'h7 : 4'h6) - {2'h0, sel})
        else $error("calibration multiple wrong");
    short_cal_a: assert property (cal_fire && !next_energy_fire |-> cal_thresh <= energy_thresh)
        else $error("calibration interval not shorter");

endmodule : epg_energy_pulse

// ### rtl/epg_pkg.sv
// Shared constants of the energy pulse output generator
package epg_pkg;

    // ------------------------------------------------------------
    // Clock and timing figures
    // ------------------------------------------------------------
    localparam int unsigned CLOCK_HZ             = 32'h017d_7840;   // 25 MHz
    localparam int unsigned CYC_PER_MS           = CLOCK_HZ / 32'h0000_03e8;
    localparam int unsigned CYC_PER_US           = CLOCK_HZ / 32'h000f_4240;
    localparam int unsigned CAL_WIDTH_MS         = 32'h0000_00b4;   // 180 ms
    localparam int unsigned CAL_HALF_LIMIT_MS    = 32'h0000_0168;   // 360 ms
    localparam int unsigned ENERGY_HALF_LIMIT_MS = 32'h0000_044c;   // 1100 ms
    localparam int unsigned ENERGY_WIDTH_MS      = 32'h0000_0113;   // 275 ms nominal
    localparam int unsigned HF_WIDTH_US          = 32'h0000_0024;   // 36 us
    localparam int unsigned CAL_WIDTH_CYC        = CAL_WIDTH_MS * CYC_PER_MS;
    localparam int unsigned CAL_HALF_LIMIT_CYC   = CAL_HALF_LIMIT_MS * CYC_PER_MS;
    localparam int unsigned ENERGY_HALF_LIMIT_CYC = ENERGY_HALF_LIMIT_MS * CYC_PER_MS;
    localparam int unsigned ENERGY_WIDTH_CYC     = ENERGY_WIDTH_MS * CYC_PER_MS;
    localparam int unsigned HF_WIDTH_CYC         = HF_WIDTH_US * CYC_PER_US;

    // ------------------------------------------------------------
    // Rate selection
    // ------------------------------------------------------------
    localparam logic [1:0] SEL_HF         = 2'h3;   // code 11
    localparam logic [3:0] SHIFT_SCF_HI   = 4'h7;   // 128x at code 00
    localparam logic [3:0] SHIFT_SCF_LO   = 4'h6;   // 64x at code 00
    localparam logic [3:0] SHIFT_HF       = 4'hb;   // 2048x
    localparam int unsigned NOLOAD_PPM    = 32'h0000_000e;   // 14 per million
    localparam int unsigned MILLION       = 32'h000f_4240;

    // ------------------------------------------------------------
    // Counters
    // ------------------------------------------------------------
    localparam int unsigned CNT_W = 32;

endpackage : epg_pkg

// ### rtl/epg_pulse_timer.sv
// Pulse width timer with period measurement and half-period shortening
module epg_pulse_timer
    import epg_pkg::*;
#(
    parameter int unsigned NOMINAL_CYC    = CAL_WIDTH_CYC,
    parameter int unsigned HALF_LIMIT_CYC = CAL_HALF_LIMIT_CYC,
    parameter int unsigned FIXED_CYC      = HF_WIDTH_CYC
) (
    // Clock and reset
    input  wire logic clock,
    input  wire logic resetn,
    // Control
    input  wire logic fire,
    input  wire logic fixed_mode,
    // Pulse
    output logic      active
);

    localparam logic [CNT_W-1:0] CNT_SAT  = {CNT_W{1'b1}};
    localparam logic [CNT_W-1:0] CNT_ONE  = {{(CNT_W-1){1'b0}}, 1'b1};
    localparam logic [CNT_W-1:0] CNT_ZERO = {CNT_W{1'b0}};
    localparam logic [CNT_W-1:0] NOM_W    = CNT_W'(NOMINAL_CYC);
    localparam logic [CNT_W-1:0] LIMIT_W  = CNT_W'(HALF_LIMIT_CYC);
    localparam logic [CNT_W-1:0] FIXED_W  = CNT_W'(FIXED_CYC);

    if (NOMINAL_CYC == 0 || FIXED_CYC == 0 || HALF_LIMIT_CYC < 2) begin : g_bad_cfg
        $error("pulse timer widths must be nonzero");
    end

    // ------------------------------------------------------------
    // Period and width counters
    // ------------------------------------------------------------
    logic [CNT_W-1:0] since;
    logic [CNT_W-1:0] width;
    logic [CNT_W-1:0] next_since;
    logic [CNT_W-1:0] next_width;
    logic [CNT_W-1:0] half;

    always_comb begin
        half       = (since >> 1) == CNT_ZERO ? CNT_ONE : since >> 1;
        next_since = (since == CNT_SAT) ? since : since + CNT_ONE;
        next_width = (width != CNT_ZERO) ? width - CNT_ONE : CNT_ZERO;
        if (fire) begin
            next_since = CNT_ONE;
            if (fixed_mode) begin
                next_width = FIXED_W;
            end else if (since < LIMIT_W) begin
                next_width = half;
            end else begin
                next_width = NOM_W;
            end
        end
    end

    // Saturated start: outside fixed mode, the first pulse after reset gets the nominal width
    always_ff @(posedge clock or negedge resetn) begin
        if (!resetn) begin
            since <= {CNT_W{1'b1}};
            width <= {CNT_W{1'b0}};
        end else begin
            since <= next_since;
            width <= next_width;
        end
    end

    assign active = (width != CNT_ZERO);

    // ------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------
    fixed_width_a: assert property (@(posedge clock) disable iff (!resetn)
        fire && fixed_mode |=> width == FIXED_W) else $error("fixed width not loaded");
    half_width_a: assert property (@(posedge clock) disable iff (!resetn)
        fire && !fixed_mode && since < LIMIT_W |=> width == $past(half))
        else $error("short period did not halve width");
    nominal_width_a: assert property (@(posedge clock) disable iff (!resetn)
        fire && !fixed_mode && since >= LIMIT_W |=> width == NOM_W)
        else $error("nominal width not loaded");

endmodule : epg_pulse_timer

// ### tb/epg_pulse_counter.sv
// Impulse counter model that tallies the three pulse outputs
module epg_pulse_counter (
    // Clock and reset
    input  wire logic        clock,
    input  wire logic        resetn,
    // Pulse inputs
    input  wire logic        energy_pulse_a,
    input  wire logic        energy_pulse_b,
    input  wire logic        calibration_pulse_out,
    // Tallies
    output logic      [31:0] count_a,
    output logic      [31:0] count_b,
    output logic      [31:0] count_cal,
    output logic      [31:0] width_e,
    output logic      [31:0] width_cal,
    output logic      [7:0]  order
);
    timeunit 1ns;
    timeprecision 1ps;

    logic [31:0] run_e;
    logic [31:0] run_c;
    logic        last_a;
    logic        last_b;
    logic        last_c;

    // Widths count the sampled active edges, so they compare to cycles
    always @(posedge clock or negedge resetn) begin
        if (!resetn) begin
            {count_a, count_b, count_cal, width_e, width_cal} <= '0;
            {run_e, run_c, order}                             <= '0;
            {last_a, last_b, last_c}                          <= 3'h6;
        end else begin
            last_a <= energy_pulse_a;
            last_b <= energy_pulse_b;
            last_c <= calibration_pulse_out;
            if (last_a && !energy_pulse_a) begin
                count_a <= count_a + 32'h1;
                order   <= {order[6:0], 1'b0};
            end
            if (last_b && !energy_pulse_b) begin
                count_b <= count_b + 32'h1;
                order   <= {order[6:0], 1'b1};
            end
            if (!last_c && calibration_pulse_out) begin
                count_cal <= count_cal + 32'h1;
            end
            run_e <= (!energy_pulse_a || !energy_pulse_b) ? run_e + 32'h1 : 32'h0;
            run_c <= calibration_pulse_out ? run_c + 32'h1 : 32'h0;
            if ((!last_a || !last_b) && energy_pulse_a && energy_pulse_b) begin
                width_e <= run_e;
            end
            if (last_c && !calibration_pulse_out) begin
                width_cal <= run_c;
            end
        end
    end
endmodule : epg_pulse_counter

// ### tb/test_epg_energy_pulse.sv
// Self-checking bench of the energy pulse output generator
module test_epg_energy_pulse;
    timeunit 1ns;
    timeprecision 1ps;

    logic        clock;
    logic        resetn;
    logic [23:0] power_sample;
    logic        power_valid;
    logic        freq_select_lo;
    logic        freq_select_hi;
    logic        cal_scale_select;
    logic        energy_pulse_a;
    logic        energy_pulse_b;
    logic        calibration_pulse_out;
    logic [31:0] count_a, count_b, count_cal, width_e, width_cal;
    logic [7:0]  order;
    int          mismatches;
    int          checks_done;
    int          cycles;

    // ------------------------------------------------------------
    // Design and counter
    // ------------------------------------------------------------
    // Short widths and a small energy scale keep the run brief
    epg_energy_pulse #(.ENERGY_LOG2(20), .CAL_WIDTH(20), .CAL_HALF_LIMIT(40),
                       .ENERGY_WIDTH(30), .ENERGY_HALF_LIMIT(120)) DUT (
        .clock(clock), .resetn(resetn), .power_sample(power_sample), .power_valid(power_valid),
        .freq_select_lo(freq_select_lo), .freq_select_hi(freq_select_hi),
        .cal_scale_select(cal_scale_select), .energy_pulse_a(energy_pulse_a),
        .energy_pulse_b(energy_pulse_b), .calibration_pulse_out(calibration_pulse_out));

    epg_pulse_counter counter (
        .clock(clock), .resetn(resetn), .energy_pulse_a(energy_pulse_a), .energy_pulse_b(energy_pulse_b),
        .calibration_pulse_out(calibration_pulse_out), .count_a(count_a), .count_b(count_b),
        .count_cal(count_cal), .width_e(width_e), .width_cal(width_cal), .order(order));

    // ------------------------------------------------------------
    // Shared tasks
    // ------------------------------------------------------------
    task automatic check(input string name, input logic [31:0] exp, input logic [31:0] got);
        checks_done++;
        if (got !== exp) begin
            mismatches++;
            $display("[FAIL] %s expected %0d seen %0d", name, exp, got);
        end
    endtask : check

    task automatic stop_test;
        if (mismatches == 0 && checks_done > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask : stop_test

    // Selects only change under reset, since they are static levels
    task automatic start(input logic scale, input logic [1:0] code);
        @(posedge clock);
        resetn           <= 1'b0;
        cal_scale_select <= scale;
        freq_select_hi   <= code[1];
        freq_select_lo   <= code[0];
        repeat (4) @(posedge clock);
        resetn <= 1'b1;
    endtask : start

    // Spaced samples keep each calibration pulse apart from the next
    task automatic send(input int n, input logic [23:0] v, input int gap);
        for (int i = 0; i < n; i++) begin
            @(posedge clock);
            power_valid  <= 1'b1;
            power_sample <= v;
            if (gap > 1) begin
                @(posedge clock);
                power_valid <= 1'b0;
                repeat (gap - 2) @(posedge clock);
            end
        end
        @(posedge clock);
        power_valid <= 1'b0;
        repeat (1000) @(posedge clock);
    endtask : send

    // ------------------------------------------------------------
    // Scenarios
    // ------------------------------------------------------------
    task automatic t_reset;
        start(1'b1, 2'h0);
        @(posedge clock);
        check("idle energy a", 32'h1, {31'h0, energy_pulse_a});
        check("idle energy b", 32'h1, {31'h0, energy_pulse_b});
        check("idle cal", 32'h0, {31'h0, calibration_pulse_out});
    endtask : t_reset

    task automatic t_ratio;
        logic [1:0] code;
        for (int s = 0; s < 2; s++) begin
            for (int c = 0; c < 4; c++) begin
                code = c[1:0];
                if (s == 0 && c == 3) continue;
                start(s[0], code);
                send((512 >> c) + 2, 24'h004000, 16);
                check("energy a count", 32'h1, count_a);
                check("energy b count", 32'h0, count_b);
                check("cal count", (s == 1) ? (32'h80 >> c) : (32'h40 >> c), count_cal);
                check("energy width", 32'h1e, width_e);
                check("cal width", 32'h14, width_cal);
            end
        end
    endtask : t_ratio

    task automatic t_alternate;
        start(1'b1, 2'h3);
        send(4 * 64 + 2, 24'h004000, 16);
        check("energy a count", 32'h2, count_a);
        check("energy b count", 32'h2, count_b);
        check("energy order", 32'h5, {28'h0, order[3:0]});
    endtask : t_alternate

    task automatic t_short_period;
        start(1'b1, 2'h3);
        send(2 * 64 + 2, 24'h004000, 1);
        check("energy b count", 32'h1, count_b);
        check("energy half width", 32'h20, width_e);
        check("cal half width", 32'h2, width_cal);
        // Nominal-width first pulse absorbs the second fire
        check("cal count", 32'h1f, count_cal);
    endtask : t_short_period

    task automatic t_high_freq;
        start(1'b0, 2'h3);
        send(2, 24'h000258, 1000);
        check("hf cal count", 32'h2, count_cal);
        check("hf cal width", 32'h384, width_cal);
        check("hf energy count", 32'h0, count_a);
    endtask : t_high_freq

    task automatic t_no_load;
        start(1'b1, 2'h0);
        send(2000, 24'h0000e9, 1);
        check("no load cal", 32'h0, count_cal);
        check("no load energy", 32'h0, count_a + count_b);
        start(1'b1, 2'h0);
        send(2000, 24'h0000ea, 1);
        check("edge load cal", 32'h7, count_cal);
    endtask : t_no_load

    // ------------------------------------------------------------
    // Clock, timeout and main sequence
    // ------------------------------------------------------------
    initial begin
        clock = 1'b0;
        forever #20 clock = ~clock;
    end

    always @(posedge clock) begin
        cycles++;
        if (cycles == 80000) begin
            mismatches++;
            stop_test();
        end
    end

    initial begin
        {resetn, power_valid, freq_select_lo, freq_select_hi, cal_scale_select} = 5'h0;
        power_sample = 24'h0;
        mismatches   = 0;
        checks_done  = 0;
        cycles       = 0;
        t_reset();
        t_ratio();
        t_alternate();
        t_short_period();
        t_high_freq();
        t_no_load();
        stop_test();
    end
endmodule : test_epg_energy_pulse
